// >>> cmc_regs.sv
// Purpose: monitor, thermistor, watchdog control and charge resume registers
// Assumes: register port strobes are one-cycle pulses, address held with them
// Notes: read data is registered, valid one cycle after the read strobe
`timescale 1ns/10ps
module cmc_regs
    import cmc_pkg::*;
#(
    parameter int REFRESH_CYCLES = CMC_REFRESH_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic BLOCKING_TRANSISTOR_PIN,
    input wire logic LINEAR_PATH_CHARGING,
    input wire logic BAT_ABOVE_MIN,
    input wire logic BAT_ABOVE_LOW,
    input wire logic POWER_GOOD_PIN_IN,
    output logic POWER_GOOD_OUT_LEVEL,
    input wire logic SHUTDOWN_PIN_LEVEL,
    input wire logic BATTERY_MISSING,
    input wire logic POST_CHARGE_ACTIVE,
    input wire logic THERM_SHORT_GND,
    input wire logic THERM_OPEN,
    input wire logic THERM_SHORT_REF,
    input wire logic [3:0] THERM_ABOVE_LEVEL,
    output logic THERMISTOR_IGNORE,
    output logic THERM_AFFECTS_CHARGE,
    output logic AUX_REGULATOR_ON,
    output logic WATCHDOG_OFF,
    output logic CHARGE_RESUME
);
    localparam int CW = $clog2(REFRESH_CYCLES + 1);

    logic [CMC_SYNC_WIDTH-1:0] raw_status;
    logic [CMC_SYNC_WIDTH-1:0] sync_status;
    logic s_gate, s_path, s_min, s_low, s_pg, s_shut, s_miss, s_post;
    logic s_gnd, s_open, s_ref;
    logic [3:0] s_level;
    logic [2:0] s_level_hi;
    logic s_level_lo;
    logic power_good_q;
    logic therm_ignore_q;
    logic [7:0] wdctl_q;
    logic [3:0] level_q;
    logic [CW-1:0] tick_q;
    logic [CW-1:0] tick_d;
    logic tick_wrap;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic resume_q;
    logic sel_mon, sel_therm, sel_wd, sel_resume;
    logic wr_mon;
    logic wr_therm;
    logic wr_wd;
    logic wr_resume;
    logic key_match;
    logic resume_d;
    logic [7:0] rd_wd;
    logic bat_level;
    logic therm_valid;
    logic [7:0] mon_rd, therm_rd, rd_mux;

    // pin and comparator levels cross through two synchroniser banks; level flags 3:1 use the second bank
    assign raw_status = {BLOCKING_TRANSISTOR_PIN, LINEAR_PATH_CHARGING,
        BAT_ABOVE_MIN, BAT_ABOVE_LOW, POWER_GOOD_PIN_IN, SHUTDOWN_PIN_LEVEL,
        BATTERY_MISSING, POST_CHARGE_ACTIVE, THERM_SHORT_GND, THERM_OPEN,
        THERM_SHORT_REF, THERM_ABOVE_LEVEL[0]};

    cmc_sync #(
        .WIDTH(CMC_SYNC_WIDTH)
    ) u_sync_status (
        .clk(SYS_CLK),
        .rst(RST),
        .async_in(raw_status),
        .sync_out(sync_status)
    );

    cmc_sync #(
        .WIDTH(3)
    ) u_sync_level (
        .clk(SYS_CLK),
        .rst(RST),
        .async_in(THERM_ABOVE_LEVEL[3:1]),
        .sync_out(s_level_hi)
    );

    // unpack the bank in the same order it was packed
    assign {s_gate, s_path, s_min, s_low, s_pg, s_shut, s_miss, s_post,
        s_gnd, s_open, s_ref, s_level_lo} = sync_status;
    // rejoin the level flags so that one net has one driver
    assign s_level = {s_level_hi, s_level_lo};

    // address decode
    assign sel_mon = (REG_ADDR == CMC_ADDR_MONITOR);
    assign sel_therm = (REG_ADDR == CMC_ADDR_THERM);
    assign sel_wd = (REG_ADDR == CMC_ADDR_WDCTL);
    assign sel_resume = (REG_ADDR == CMC_ADDR_RESUME);

    // write enables; a strobe to any other address changes nothing
    assign wr_mon = REG_WR & sel_mon;
    assign wr_therm = REG_WR & sel_therm;
    assign wr_wd = REG_WR & sel_wd;
    assign wr_resume = REG_WR & sel_resume;
    // only the exact key counts, so a stray byte cannot restart charging
    assign key_match = (REG_WDATA == CMC_RESUME_KEY);
    assign resume_d = wr_resume & key_match;

    // threshold depends on which charging path is active
    assign bat_level = s_path ? s_min : s_low;
    assign therm_valid = ~(s_gnd | s_open | s_ref);

    // monitor read image; bit 5 shows the sensed pin, not the drive
    // latch, so an external pull on the pin is visible to the host
    assign mon_rd = {s_gate, bat_level, s_pg, s_shut, s_miss, s_post,
        2'b00};

    // thermistor read image; level flags come from the once-a-second snapshot
    assign therm_rd = {2'b00, therm_ignore_q, therm_valid,
        level_q};

    // control read image; bit 0 is masked again so it can never read 1
    assign rd_wd = wdctl_q & CMC_WDCTL_RW_MASK;

    // read selection; unmapped addresses read zero
    assign rd_mux = sel_mon ? mon_rd :
        sel_therm ? therm_rd :
        sel_wd ? rd_wd :
        sel_resume ? CMC_RESUME_READ :
        CMC_UNMAPPED_READ;

    // one-second refresh counter, independent of the ignore bit; the
    // level flags are a snapshot, so a host read between ticks may lag
    // the comparators by up to one period
    assign tick_wrap = (tick_q == CW'(REFRESH_CYCLES - 1));
    assign tick_d = tick_wrap ? '0 : tick_q + CW'(1);

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            tick_q <= '0;
            level_q <= '0;
        end
        else
        begin
            tick_q <= tick_d;
            if (tick_wrap)
                level_q <= s_level;
        end
    end

    // power-good drive latch; the pin is released high out of reset
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            power_good_q <= CMC_POWER_GOOD_RESET;
        else if (wr_mon)
            power_good_q <= REG_WDATA[CMC_BIT_POWER_GOOD];
    end

    // thermistor ignore bit; the other bits of this byte are status only
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            therm_ignore_q <= CMC_THERM_IGNORE_RESET;
        else if (wr_therm)
            therm_ignore_q <= REG_WDATA[CMC_BIT_THERM_IGNORE];
    end

    // control byte; reserved bits are stored for read-back only
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            wdctl_q <= CMC_WDCTL_RESET;
        else if (wr_wd)
            wdctl_q <= REG_WDATA & CMC_WDCTL_RW_MASK;
    end

    // resume pulse; other values written here are silently ignored
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            resume_q <= 1'b0;
        else
            resume_q <= resume_d;
    end

    // read valid follows every read strobe by exactly one cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            rvalid_q <= 1'b0;
        else
            rvalid_q <= REG_RD;
    end

    // read data is held until the next read, so a slow front end can
    // pick it up at leisure
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            rdata_q <= '0;
        else if (REG_RD)
            rdata_q <= rd_mux;
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign POWER_GOOD_OUT_LEVEL = power_good_q;
    assign THERMISTOR_IGNORE = therm_ignore_q;
    assign THERM_AFFECTS_CHARGE = ~therm_ignore_q;
    assign AUX_REGULATOR_ON = wdctl_q[CMC_BIT_REG_ON];
    assign WATCHDOG_OFF = wdctl_q[CMC_BIT_WD_OFF];
    assign CHARGE_RESUME = resume_q;
endmodule

// >>> cmc_pkg.sv
// Purpose: constants for the charger monitor and control register bank
// Assumes: 8-bit register port behind the serial front end
// Notes: offsets are byte addresses of the serial register map
package cmc_pkg;
    localparam logic [7:0] CMC_ADDR_MONITOR = 8'h11;
    localparam logic [7:0] CMC_ADDR_THERM = 8'h12;
    localparam logic [7:0] CMC_ADDR_WDCTL = 8'h13;
    localparam logic [7:0] CMC_ADDR_RESUME = 8'hfa;
    localparam logic [7:0] CMC_WDCTL_RESET = 8'h6c;
    localparam logic [7:0] CMC_WDCTL_RW_MASK = 8'hfe;
    localparam logic [7:0] CMC_RESUME_KEY = 8'hb5;
    localparam logic [7:0] CMC_RESUME_READ = 8'hff;
    localparam logic [7:0] CMC_UNMAPPED_READ = 8'h00;
    localparam logic CMC_POWER_GOOD_RESET = 1'b1;
    localparam logic CMC_THERM_IGNORE_RESET = 1'b0;
    localparam int CMC_BIT_POWER_GOOD = 5;
    localparam int CMC_BIT_THERM_IGNORE = 5;
    localparam int CMC_BIT_REG_ON = 2;
    localparam int CMC_BIT_WD_OFF = 1;
    localparam int CMC_SYNC_WIDTH = 12;
    localparam int CMC_CLK_HZ = 50000000;
    localparam int CMC_REFRESH_MS = 1000;
    localparam int CMC_REFRESH_CYCLES = CMC_CLK_HZ / 1000 * CMC_REFRESH_MS;
endpackage

// >>> cmc_sync.sv
// Purpose: two-flop synchroniser for a group of status levels
// Assumes: single clock domain on the reading side
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
module cmc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // two stages, reset to zero so reads are defined from reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// >>> cmc_regs_assertions.sv
// Purpose: port checks for the charger register bank
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the bank
`timescale 1ns/10ps
module cmc_regs_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic POWER_GOOD_OUT_LEVEL,
    input wire logic THERMISTOR_IGNORE,
    input wire logic THERM_AFFECTS_CHARGE,
    input wire logic AUX_REGULATOR_ON,
    input wire logic WATCHDOG_OFF,
    input wire logic CHARGE_RESUME
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // decodes named once so the properties stay short
    wire wk = REG_WR && REG_ADDR == 8'hfa && REG_WDATA == 8'hb5;
    wire w13 = REG_WR && REG_ADDR == 8'h13;
    AST_RD_VALID: assert property (REG_RD |=> REG_RVALID)
        else $error("read valid missing");
    AST_RESUME: assert property (wk |=> CHARGE_RESUME)
        else $error("resume pulse missing");
    AST_NO_RESUME: assert property (!wk |=> !CHARGE_RESUME)
        else $error("resume pulse without key");
    AST_PGOOD: assert property (REG_WR && REG_ADDR == 8'h11 |=>
        POWER_GOOD_OUT_LEVEL == $past(REG_WDATA[5])) else $error("pgood");
    AST_IGNORE: assert property (REG_WR && REG_ADDR == 8'h12 |=>
        THERMISTOR_IGNORE == $past(REG_WDATA[5]) &&
        THERM_AFFECTS_CHARGE != THERMISTOR_IGNORE) else $error("ignore");
    AST_WD_OFF: assert property (w13 |=>
        WATCHDOG_OFF == $past(REG_WDATA[1])) else $error("watchdog off");
    AST_REG_ON: assert property (w13 |=>
        AUX_REGULATOR_ON == $past(REG_WDATA[2])) else $error("regulator");
    AST_RSVD_MON: assert property (REG_RD && REG_ADDR == 8'h11 |=>
        REG_RDATA[1:0] == 2'b00) else $error("monitor reserved bits");
    // main traffic seen at least once
    cover property (wk);
    cover property (w13);
    cover property (REG_RD && REG_ADDR == 8'h12);
endmodule
bind cmc_regs cmc_regs_chk u_chk (.SYS_CLK, .RST, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REG_RDATA, .REG_RVALID, .POWER_GOOD_OUT_LEVEL,
    .THERMISTOR_IGNORE, .THERM_AFFECTS_CHARGE, .AUX_REGULATOR_ON,
    .WATCHDOG_OFF, .CHARGE_RESUME);

// >>> cmc_host.sv
// Purpose: host model on the byte register port
// Assumes: strobes change at the falling edge only
// Notes: idle address and data are inverted so stale values never match
`timescale 1ns/10ps
module cmc_host (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    // idle bus at time zero
    initial
    begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // one write strobe across exactly one rising edge
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask
    // read answer stands for the cycle after the strobe edge
    task automatic get(input logic [7:0] a, output logic [7:0] q,
        output logic v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        q = rdata;
        v = rvalid;
        rd = 1'b0;
        addr = ~a;
    endtask
endmodule

// >>> cmc_regs_test.sv
// Purpose: random and corner checks of the charger register bank
// Assumes: short refresh period of 8 cycles
// Notes: expected images are rebuilt from the stimulus vector
`timescale 1ns/10ps
module cmc_regs_test;
    logic clk, rst, wr, rd, v, gv, pgo, ign, aff, aux, wdo, res, ig;
    logic [7:0] a, d, q, g;
    logic [14:0] s;
    logic [31:0] r = 32'h58;
    int err_count = 0;
    int checks_done = 0;
    cmc_host h (.clk(clk), .addr(a), .wdata(d), .wr(wr), .rd(rd),
        .rdata(q), .rvalid(v));
    cmc_regs #(.REFRESH_CYCLES(8)) dut (.SYS_CLK(clk), .RST(rst),
        .REG_ADDR(a), .REG_WDATA(d), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(q), .REG_RVALID(v), .BLOCKING_TRANSISTOR_PIN(s[0]),
        .LINEAR_PATH_CHARGING(s[1]), .BAT_ABOVE_MIN(s[2]),
        .BAT_ABOVE_LOW(s[3]), .POWER_GOOD_PIN_IN(s[4]),
        .POWER_GOOD_OUT_LEVEL(pgo), .SHUTDOWN_PIN_LEVEL(s[5]),
        .BATTERY_MISSING(s[6]), .POST_CHARGE_ACTIVE(s[7]),
        .THERM_SHORT_GND(s[8]), .THERM_OPEN(s[9]), .THERM_SHORT_REF(s[10]),
        .THERM_ABOVE_LEVEL(s[14:11]), .THERMISTOR_IGNORE(ign),
        .THERM_AFFECTS_CHARGE(aff), .AUX_REGULATOR_ON(aux),
        .WATCHDOG_OFF(wdo), .CHARGE_RESUME(res));
    // xorshift keeps the random run repeatable
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // monitor image: the battery bit follows the active charge path
    function automatic logic [7:0] mon(input logic [14:0] x);
        return {x[0], x[1] ? x[2] : x[3], x[4], x[5], x[6], x[7], 2'b00};
    endfunction
    task automatic chk(input string n, input logic [7:0] e,
        input logic [7:0] got);
        checks_done++;
        if (got !== e)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // clock of 20 ns
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watchdog sized well above the roughly 1040 cycles of the run
    initial
    begin
        repeat (5000) @(posedge clk);
        err_count++;
        stop_test;
    end
    // main sequence
    initial
    begin
        rst = 1'b1;
        s = '0;
        ig = 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk("reset pins", 8'h16, {3'd0, pgo, ign, aff, aux, wdo});
        h.get(8'h13, g, gv);
        chk("wdctl reset", 8'h6c, g);
        for (int i = 0; i < 40; i++)
        begin
            r = xs(r);
            @(negedge clk) s = r[14:0];
            repeat (12) @(negedge clk);
            h.get(8'h11, g, gv);
            chk("monitor", mon(s), g);
            chk("valid", 8'h01, {7'd0, gv});
            h.get(8'h12, g, gv);
            chk("therm", {2'b00, ig, ~|s[10:8], s[14:11]}, g);
            h.put(8'h13, r[23:16]);
            h.get(8'h13, g, gv);
            chk("wdctl", r[23:16] & 8'hfe, g);
            h.put(8'h12, r[31:24]);
            ig = r[29];
            h.put(8'h11, r[31:24]);
            chk("pins", {3'd0, ig, ig, ~ig, r[18], r[17]},
                {3'd0, pgo, ign, aff, aux, wdo});
        end
        h.put(8'hfa, 8'hb5);
        chk("resume", 8'h01, {7'd0, res});
        h.put(8'hfa, 8'hb4);
        chk("no resume", 8'h00, {7'd0, res});
        h.get(8'hfa, g, gv);
        chk("resume read", 8'hff, g);
        h.get(8'h40, g, gv);
        chk("unmapped", 8'h00, g);
        // mid-run reset with every level comparator high: the flags must
        // read zero until the first refresh tick, and only then follow
        @(negedge clk) rst = 1'b1;
        s = 15'h7800;
        ig = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk("rerst pins", 8'h16, {3'd0, pgo, ign, aff, aux, wdo});
        h.get(8'h13, g, gv);
        chk("rerst wdctl", 8'h6c, g);
        h.get(8'h12, g, gv);
        chk("therm hold", 8'h10, g);
        repeat (12) @(negedge clk);
        h.get(8'h12, g, gv);
        chk("therm tick", 8'h1f, g);
        stop_test;
    end
endmodule
